// ==== include/fsq_pkg.sv ====
package fsq_pkg;
  // ****************************************************************
  // bus map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;  // memory_control_reg
  localparam logic [7:0] ADDR_KEY     = 8'h04;  // unlock_key_reg
  localparam logic [7:0] ADDR_LATCH   = 8'h08;  // table_latch
  localparam logic [7:0] ADDR_PTR     = 8'h0c;  // table_pointer, 22 bits
  localparam logic [7:0] ADDR_TBLOP   = 8'h10;  // table operation command
  localparam logic [7:0] ADDR_STATUS  = 8'h14;  // stall (bit 0) / erase in progress (bit 1)

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTRL_START_BIT  = 1;
  localparam int CTRL_PROGRAM_WRITE_ENABLE_BIT   = 2;
  localparam int CTRL_ERR_BIT    = 3;
  localparam int CTRL_ERASE_BIT  = 4;
  localparam int CTRL_CONFIG_SPACE_SELECT_BIT   = 6;

  // ****************************************************************
  // table operation command fields
  // ****************************************************************
  localparam int TBLOP_WRITE_BIT = 2;
  localparam int TBLOP_MODE_LSB  = 0;

  // ****************************************************************
  // sizes and constants
  // ****************************************************************
  localparam int PTR_W           = 22;
  localparam int ADDR_W          = 21;
  localparam int WORD_ADDR_W     = 20;
  localparam int HOLD_N          = 16;
  localparam int HOLD_IDX_W      = 4;
  localparam int ROW_BYTES       = 64;
  localparam int ROW_LSB         = 6;
  localparam int BLOCK_LSB       = 4;
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [7:0] HOLD_RESET = 8'hff;
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ          = 20_000_000;
  localparam int LONG_WRITE_US   = 2000;
  localparam int LONG_WRITE_CYC  = LONG_WRITE_US * (CLK_HZ / 1_000_000);

  typedef enum logic [1:0]
  {
    PTR_KEEP,
    PTR_POST_INC,
    PTR_POST_DEC,
    PTR_PRE_INC
  } fsq_ptr_mode_e;

  typedef enum logic [1:0]
  {
    LW_IDLE,
    LW_ERASE,
    LW_PROGRAM
  } fsq_lw_state_e;
endpackage

// ==== include/fsq_flash_if.sv ====
`timescale 1ns/1ns
interface fsq_flash_if;
  import fsq_pkg::*;
  logic [WORD_ADDR_W-1:0] word_addr;
  logic [15:0]            word_rdata;
  logic                   erase_go;
  logic                   prog_go;
  logic [ADDR_W-1:0]      target;
  logic [7:0]             hold_data [HOLD_N];
  logic                   done;

  modport seq
  (
    output word_addr,
    input  word_rdata,
    output erase_go,
    output prog_go,
    output target,
    output hold_data,
    input  done
  );
  modport arr
  (
    input  word_addr,
    output word_rdata,
    input  erase_go,
    input  prog_go,
    input  target,
    input  hold_data,
    output done
  );
endinterface

// ==== rtl/fsq_flash_array.sv ====
`timescale 1ns/1ns
module fsq_flash_array
  import fsq_pkg::*;
#(
  parameter int WORDS    = 4096,
  parameter int LW_CYC   = LONG_WRITE_CYC
)
(
  input  wire logic clk,
  input  wire logic rst_b,
  fsq_flash_if.arr  fl
);
  // ****************************************************************
  // word-organised flash array with internal programming timer
  // ****************************************************************
  localparam int IW = $clog2(WORDS);

  logic [15:0] mem_q [WORDS];
  logic [31:0] tmr_q;
  logic        busy_q;
  logic        erase_q;
  logic [IW-1:0] widx;

  assign widx          = fl.word_addr[IW-1:0];
  assign fl.word_rdata = mem_q[widx];

  // programming timer ends each long write (R10) (R24)
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tmr_q   <= 32'h0;
      busy_q  <= 1'b0;
      erase_q <= 1'b0;
    end
    else if (!busy_q && (fl.erase_go || fl.prog_go))
    begin
      tmr_q   <= 32'(LW_CYC - 1);
      busy_q  <= 1'b1;
      erase_q <= fl.erase_go;
    end
    else if (busy_q && tmr_q != 32'h0)
      tmr_q <= tmr_q - 32'h1;
    else
      busy_q <= 1'b0;
  end

  assign fl.done = busy_q && (tmr_q == 32'h0);

  // array update at end of long write; no reset on contents
  genvar g;
  generate
    for (g = 0; g < WORDS; g++)
    begin : g_word
      localparam logic [IW-1:0] WI = IW'(g);
      always_ff @(posedge clk)
      begin
        if (fl.done && erase_q
            && WI[IW-1:ROW_LSB-1] == fl.target[IW:ROW_LSB])  // (R4) (R5)
          mem_q[g] <= 16'hffff;
        else if (fl.done && !erase_q
                 && WI[IW-1:BLOCK_LSB-1] == fl.target[IW:BLOCK_LSB])  // (R12) (R19)
          mem_q[g] <= mem_q[g]
                      & {fl.hold_data[2*(g%8)+1], fl.hold_data[2*(g%8)]};  // (R17) (R18)
      end
    end
  endgenerate
endmodule // fsq_flash_array

// ==== rtl/fsq_sequencer.sv ====
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
// How it works
// (R1) each table read moves one byte only
// (R2) table read copies pointed byte into latch, pointer may auto-update
// (R3) byte address bit zero picks low or high byte of a word
// (R4) erase unit is a 64-byte row; no word or bulk erase
// (R5) erase row chosen by pointer bits 21..6, low six ignored
// (R6) erase only when write enable and erase select are set at start
// (R7) start needs key 55h then aah written first
// (R8) core loads pointer, clears config select, sets enables, masks irqs
// (R9) start after unlock begins erase, stalls core about 2 ms
// (R10) core halted during long write; internal timer ends it
// (R11) core re-enables interrupts after the stall
// (R12) programming unit is a 16-byte block
// (R13) sixteen byte holding registers loaded one per table write
// (R14) table write only touches the holding register, not the array
// (R15) control write after loading starts block programming long write
// (R16) holding registers are ffh at reset and after each write
// (R17) ffh leaves a byte unchanged; programming only clears bits
// (R18) programming may start with some holding registers unloaded
// (R19) pointer bits 3..0 pick holding register; upper bits pick block
// (R20) start bit set-only by software, cleared by hardware at end
// (R21) pointer modes: keep, post-inc, post-dec, pre-inc on low 21 bits
// (R22) pointer is 22 bits; top bit selects config space
// (R23) start ignored unless both keys were the two writes just before
// (R24) long write length is a parameter; stall held throughout
module fsq_sequencer
  import fsq_pkg::*;
#(
  parameter int LW_CYC = LONG_WRITE_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             core_stall
);
  fsq_flash_if fl ();

  fsq_flash_array #(.LW_CYC(LW_CYC)) u_array
  (
    .clk   (clk),
    .rst_b (rst_b),
    .fl    (fl)
  );

  // ****************************************************************
  // state
  // ****************************************************************
  logic [PTR_W-1:0]  ptr_q;
  logic [7:0]        latch_q;
  logic              config_space_select_q;
  logic              erase_sel_q;
  logic              program_write_enable_q;
  logic              start_q;
  logic              err_q;
  logic [1:0]        key_q;
  logic [7:0]        hold_q [HOLD_N];
  fsq_lw_state_e     lw_q;

  // ****************************************************************
  // axi write channel
  // ****************************************************************
  logic              aw_got_q;
  logic              w_got_q;
  logic [7:0]        aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              wr_fire;
  logic              wr_ok;

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign wr_fire       = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      aw_addr_q <= 8'h0;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
      end
    end
  end

  always_comb
  begin
    unique case (aw_addr_q)
      ADDR_CTRL, ADDR_KEY, ADDR_LATCH, ADDR_PTR, ADDR_TBLOP, ADDR_STATUS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // decoded write strobes; byte lane 0 carries all 8-bit registers
  logic wr_ctrl;
  logic wr_key;
  logic wr_latch;
  logic wr_ptr;
  logic wr_tblop;
  logic lane0;

  assign lane0    = w_strb_q[0];
  assign wr_ctrl  = wr_fire && aw_addr_q == ADDR_CTRL && lane0;
  assign wr_key   = wr_fire && aw_addr_q == ADDR_KEY && lane0;
  assign wr_latch = wr_fire && aw_addr_q == ADDR_LATCH && lane0;
  assign wr_ptr   = wr_fire && aw_addr_q == ADDR_PTR;
  assign wr_tblop = wr_fire && aw_addr_q == ADDR_TBLOP && lane0;

  // ****************************************************************
  // unlock key tracker
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      key_q <= 2'd0;
    else if (wr_key && w_data_q[7:0] == KEY_FIRST)
      key_q <= 2'd1;                                          // (R7)
    else if (wr_key && key_q == 2'd1 && w_data_q[7:0] == KEY_SECOND)
      key_q <= 2'd2;                                          // (R7)
    else if (wr_fire)
      key_q <= 2'd0;                                          // (R23)
  end

  // ****************************************************************
  // table operations
  // ****************************************************************
  fsq_ptr_mode_e    mode;
  logic             tbl_rd;
  logic             tbl_wr;
  logic [ADDR_W-1:0] acc_addr;
  logic [ADDR_W-1:0] low_ptr;

  assign mode     = fsq_ptr_mode_e'(w_data_q[TBLOP_MODE_LSB +: 2]);
  assign tbl_rd   = wr_tblop && !w_data_q[TBLOP_WRITE_BIT] && lw_q == LW_IDLE;
  assign tbl_wr   = wr_tblop && w_data_q[TBLOP_WRITE_BIT] && lw_q == LW_IDLE;
  assign low_ptr  = ptr_q[ADDR_W-1:0];
  assign acc_addr = (mode == PTR_PRE_INC) ? low_ptr + 21'h1 : low_ptr;  // (R21)

  assign fl.word_addr = acc_addr[ADDR_W-1:1];                 // (R3)

  // config space reads back as erased; array only holds program space
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      latch_q <= 8'h0;
    else if (tbl_rd)
      latch_q <= ptr_q[PTR_W-1] ? 8'hff                         // (R22)
               : (acc_addr[0] ? fl.word_rdata[15:8] : fl.word_rdata[7:0]);  // (R1) (R2) (R3)
    else if (wr_latch)
      latch_q <= w_data_q[7:0];
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ptr_q <= 22'h0;
    else if (wr_ptr)
      ptr_q <= w_data_q[PTR_W-1:0];                             // (R22)
    else if (tbl_rd || tbl_wr)
    begin
      unique case (mode)
        PTR_KEEP:     ptr_q <= ptr_q;
        PTR_POST_INC: ptr_q[ADDR_W-1:0] <= low_ptr + 21'h1;     // (R21)
        PTR_POST_DEC: ptr_q[ADDR_W-1:0] <= low_ptr - 21'h1;     // (R21)
        PTR_PRE_INC:  ptr_q[ADDR_W-1:0] <= acc_addr;            // (R21)
      endcase
    end
  end

  // ****************************************************************
  // holding registers
  // ****************************************************************
  genvar h;
  generate
    for (h = 0; h < HOLD_N; h++)
    begin : g_hold
      always_ff @(posedge clk or negedge rst_b)
      begin
        if (!rst_b)
          hold_q[h] <= HOLD_RESET;                                // (R16)
        else if (fl.done)
          hold_q[h] <= HOLD_RESET;                                // (R16)
        else if (tbl_wr && acc_addr[HOLD_IDX_W-1:0] == HOLD_IDX_W'(h))
          hold_q[h] <= latch_q;                                   // (R13) (R14) (R19)
      end
      assign fl.hold_data[h] = hold_q[h];
    end
  endgenerate

  // ****************************************************************
  // control register and long write sequencing
  // ****************************************************************
  logic start_req;
  logic go;

  assign start_req = wr_ctrl && w_data_q[CTRL_START_BIT] && !start_q;
  assign go        = start_req && key_q == 2'd2 && program_write_enable_q && !config_space_select_q  // (R7) (R23)
                     && lw_q == LW_IDLE;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      config_space_select_q      <= 1'b0;
      erase_sel_q <= 1'b0;
      program_write_enable_q      <= 1'b0;
      err_q       <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && lw_q == LW_IDLE)
      begin
        config_space_select_q      <= w_data_q[CTRL_CONFIG_SPACE_SELECT_BIT];
        erase_sel_q <= w_data_q[CTRL_ERASE_BIT];
        program_write_enable_q      <= w_data_q[CTRL_PROGRAM_WRITE_ENABLE_BIT];
        err_q       <= w_data_q[CTRL_ERR_BIT];
      end
      if (start_req && !go)
        err_q <= 1'b1;
      if (fl.done && lw_q == LW_ERASE)
        erase_sel_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      start_q <= 1'b0;
    else if (go)
      start_q <= 1'b1;                                            // (R20)
    else if (fl.done)
      start_q <= 1'b0;                                            // (R20)
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      lw_q <= LW_IDLE;
    else
    begin
      unique case (lw_q)
        LW_IDLE:
          if (go)
            lw_q <= erase_sel_q ? LW_ERASE : LW_PROGRAM;          // (R6) (R9) (R15)
        LW_ERASE, LW_PROGRAM:
          if (fl.done)
            lw_q <= LW_IDLE;                                      // (R10)
        default:
          lw_q <= LW_IDLE;
      endcase
    end
  end

  assign fl.erase_go = go && erase_sel_q;                         // (R4) (R6)
  assign fl.prog_go  = go && !erase_sel_q;                        // (R12) (R18)
  assign fl.target   = low_ptr;                                   // (R5) (R19)
  assign core_stall  = lw_q != LW_IDLE;                           // (R9) (R10) (R24)

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  logic [31:0] rd_val;
  logic        rd_ok;

  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL:
      begin
        rd_val[CTRL_CONFIG_SPACE_SELECT_BIT]  = config_space_select_q;
        rd_val[CTRL_ERASE_BIT] = erase_sel_q;
        rd_val[CTRL_ERR_BIT]   = err_q;
        rd_val[CTRL_PROGRAM_WRITE_ENABLE_BIT]  = program_write_enable_q;
        rd_val[CTRL_START_BIT] = start_q;
      end
      ADDR_KEY:    rd_val = 32'h0;
      ADDR_LATCH:  rd_val[7:0] = latch_q;
      ADDR_PTR:    rd_val[PTR_W-1:0] = ptr_q;
      ADDR_TBLOP:  rd_val = 32'h0;
      ADDR_STATUS: rd_val[1:0] = {lw_q == LW_ERASE, core_stall};
      default:     rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= AXI_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule // fsq_sequencer

// ==== sim/fsq_seq_properties.sv ====
`timescale 1ns/1ns
// ****************************************
// port checker for the sequencer
// ****************************************
module fsq_seq_properties
  import fsq_pkg::*;
#(
  parameter int LW_CYC = LONG_WRITE_CYC
)
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        core_stall
);
  int unsigned cnt_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= 0;
    else
      cnt_q <= core_stall ? cnt_q + 1 : 0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_stall_length: assert property ($fell(core_stall) |-> cnt_q == LW_CYC)
    else $error("long write length wrong");
  a_stall_cap: assert property (cnt_q <= LW_CYC)
    else $error("long write overran");
  a_stall_start: assert property ($rose(core_stall) |-> $rose(s_axi_bvalid))
    else $error("stall without start write");
  a_status_stall: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS
    |=> s_axi_rdata[0] == $past(core_stall))
    else $error("status stall bit wrong");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken with response pending");
endmodule // fsq_seq_properties

bind fsq_sequencer fsq_seq_properties #(.LW_CYC(LW_CYC)) i_fsq_seq_properties
(
  .clk(clk), .rst_b(rst_b), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .core_stall(core_stall)
);

// ==== sim/fsq_core_model.sv ====
`timescale 1ns/1ns
// ****************************************
// processor core issuing register accesses
// ****************************************
module fsq_core_model
  import fsq_pkg::*;
(
  input wire logic        clk,
  output logic [7:0]      awaddr,
  output logic            awvalid,
  input wire logic        awready,
  output logic [31:0]     wdata,
  output logic [3:0]      wstrb,
  output logic            wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  output logic            bready,
  output logic [7:0]      araddr,
  output logic            arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  output logic            rready,
  input wire logic        core_stall
);
  logic       global_irq_enable;
  logic [1:0] last_resp;

  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    global_irq_enable = 1'b1;
    last_resp = 2'b00;
  end

  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    last_resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    v = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask

  // long write: set up, unlock, start, wait out the stall
  task go(input logic er, output logic [31:0] st);
    logic [31:0] c;
    c = (32'h1 << CTRL_PROGRAM_WRITE_ENABLE_BIT) | (32'(er) << CTRL_ERASE_BIT);
    wr(ADDR_CTRL, c);
    global_irq_enable = 1'b0;
    wr(ADDR_KEY, 32'(KEY_FIRST));
    wr(ADDR_KEY, 32'(KEY_SECOND));
    wr(ADDR_CTRL, c | (32'h1 << CTRL_START_BIT));
    rd(ADDR_STATUS, st);
    while (core_stall)
      @(posedge clk);
    global_irq_enable = 1'b1;
  endtask
endmodule // fsq_core_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
// ****************************************
// sequencer testbench
// ****************************************
module testbench
  import fsq_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, core_stall;
  logic        stall_d = 1'b0;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          n_lw = 0;
  localparam logic [31:0] PROGRAM_WRITE_ENABLE = 32'h1 << CTRL_PROGRAM_WRITE_ENABLE_BIT;
  localparam logic [31:0] GO = 32'h1 << CTRL_START_BIT;

  always #25 clk = ~clk;

  always @(posedge clk)
  begin
    if (core_stall === 1'b1 && stall_d !== 1'b1)
      n_lw++;
    stall_d <= core_stall;
  end

  fsq_sequencer #(.LW_CYC(8)) i_fsq_sequencer
  (
    .clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_stall(core_stall)
  );

  fsq_core_model i_fsq_core_model
  (
    .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .core_stall(core_stall)
  );

  task results;
    $display("mismatches %0d, compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task w(input logic [7:0] a, input logic [31:0] v);
    i_fsq_core_model.wr(a, v);
  endtask

  task r(input logic [7:0] a);
    i_fsq_core_model.rd(a, d);
  endtask

  task rbyte(input logic [31:0] p, input logic [7:0] e);
    w(ADDR_PTR, p);
    w(ADDR_TBLOP, 32'(PTR_KEEP));
    r(ADDR_LATCH);
    chk("flash byte", {24'h0, e}, d);
  endtask

  task tw(input logic [7:0] v, input fsq_ptr_mode_e m);
    w(ADDR_LATCH, {24'h0, v});
    w(ADDR_TBLOP, (32'h1 << TBLOP_WRITE_BIT) | 32'(m));
  endtask

  task lw(input logic er);
    i_fsq_core_model.go(er, d);
    chk("status stall", 32'h1, {31'h0, d[0]});
    chk("status erase", {31'h0, er}, {31'h0, d[1]});
  endtask

  task op(input fsq_ptr_mode_e m, input logic [31:0] ep, input logic [7:0] el);
    w(ADDR_TBLOP, 32'(m));
    r(ADDR_PTR);
    chk("pointer", ep, d);
    r(ADDR_LATCH);
    chk("latch", {24'h0, el}, d);
  endtask

  task t_regs;
    r(ADDR_CTRL);
    chk("ctrl reset", 32'h0, d);
    r(ADDR_PTR);
    chk("ptr reset", 32'h0, d);
    w(8'h18, 32'h0);
    chk("bresp", {30'h0, AXI_SLVERR}, {30'h0, i_fsq_core_model.last_resp});
    r(8'h18);
    chk("rresp", {30'h0, AXI_SLVERR}, {30'h0, i_fsq_core_model.last_resp});
  endtask

  task t_erase;
    w(ADDR_PTR, 32'h0);
    lw(1'b1);
    w(ADDR_PTR, 32'h7f);
    lw(1'b1);
    chk("long writes", 32'd2, 32'(n_lw));
    r(ADDR_CTRL);
    chk("ctrl after erase", PROGRAM_WRITE_ENABLE, d);
    for (int i = 0; i < 128; i += 9)
      rbyte(i, 8'hff);
  endtask

  task t_prog;
    w(ADDR_PTR, 32'h40);
    for (int i = 0; i < 8; i++)
      tw(8'h3c + 8'(i), PTR_POST_INC);
    r(ADDR_PTR);
    chk("ptr after loads", 32'h48, d);
    rbyte(32'h41, 8'hff);
    lw(1'b0);
    for (int i = 0; i < 16; i++)
      rbyte(32'h40 + i, i < 8 ? 8'h3c + 8'(i) : 8'hff);
  endtask

  task t_clear;
    w(ADDR_PTR, 32'h50);
    tw(8'h0f, PTR_KEEP);
    lw(1'b0);
    rbyte(32'h50, 8'h0f);
    rbyte(32'h53, 8'hff);
    w(ADDR_PTR, 32'h40);
    tw(8'hf0, PTR_KEEP);
    lw(1'b0);
    rbyte(32'h40, 8'h30);
  endtask

  task t_modes;
    w(ADDR_PTR, 32'h40);
    op(PTR_POST_INC, 32'h41, 8'h30);
    op(PTR_POST_DEC, 32'h40, 8'h3d);
    op(PTR_PRE_INC, 32'h41, 8'h3d);
    op(PTR_KEEP, 32'h41, 8'h3d);
    w(ADDR_PTR, 32'h3fffff);
    op(PTR_POST_INC, 32'h200000, 8'hff);
  endtask

  task t_refuse;
    int n0;
    n0 = n_lw;
    w(ADDR_CTRL, PROGRAM_WRITE_ENABLE);
    w(ADDR_KEY, 32'h55);
    w(ADDR_PTR, 32'h40);
    w(ADDR_KEY, 32'haa);
    w(ADDR_CTRL, PROGRAM_WRITE_ENABLE | GO);
    r(ADDR_CTRL);
    chk("start err", 32'h1, {30'h0, d[CTRL_START_BIT], d[CTRL_ERR_BIT]});
    w(ADDR_KEY, 32'haa);
    w(ADDR_KEY, 32'h55);
    w(ADDR_CTRL, PROGRAM_WRITE_ENABLE | GO);
    w(ADDR_CTRL, 32'h1 << CTRL_ERASE_BIT);
    w(ADDR_KEY, 32'h55);
    w(ADDR_KEY, 32'haa);
    w(ADDR_CTRL, (32'h1 << CTRL_ERASE_BIT) | GO);
    r(ADDR_CTRL);
    chk("ctrl refused", (32'h1 << CTRL_ERASE_BIT) | (32'h1 << CTRL_ERR_BIT), d);
    chk("refused starts", 32'(n0), 32'(n_lw));
  endtask

  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_erase;
    t_prog;
    t_clear;
    t_modes;
    t_refuse;
    results;
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("BAD watchdog expected finish seen hang");
    results;
  end
endmodule // testbench
